// *** core/mpm_pkg.sv ***
// Constants for the port G/H/J pin multiplexer.
package mpm_pkg;
  // ==========================================================================
  // Port widths and pin positions
  // ==========================================================================
  localparam int PORT_W     = 7;
  localparam int PJ_W       = 8;
  localparam int G_RXER     = 6;
  localparam int G_RXDV     = 5;
  localparam int G_RXCLK    = 4;
  localparam int H_TXER     = 6;
  localparam int H_TXEN     = 5;
  localparam int H_TXCLK    = 4;
  localparam int J_COL      = 3;
  localparam int J_CRS      = 2;
  localparam int J_MDIO     = 1;
  localparam int J_SCL      = 7;
  localparam int J_SDA      = 6;
  // Port J pins handled here (bit 0 and bits 5:4 stay plain GPIO)
  localparam logic [7:0] PJ_MII_MASK = 8'h0E;
  localparam logic [7:0] PJ_I2C_MASK = 8'hC0;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [6:0] RST_DIR7  = 7'h00;
  localparam logic [7:0] RST_DIR8  = 8'h00;
  localparam logic [6:0] RST_DAT7  = 7'h00;
  localparam logic [7:0] RST_DAT8  = 8'h00;
endpackage : mpm_pkg

// *** core/mpm_pin_mux.sv ***
// Pin multiplexer for ports G, H and J with key-wakeup detection.
// How it works
// [R1] Pins are plain GPIO unless function enabled.
// [R2] Port G carries MII receive signals.
// [R3] Port H carries MII transmit signals.
// [R4] Port J carries collision, carrier sense, MDIO.
// [R5] Port J bits 7,6 carry I2C clock/data.
// [R6] Every pin may raise a wakeup flag.
// [R7] Reset leaves all pins high-impedance inputs.
// [R8] Owning peripheral drives direction and value.
`timescale 1ns/1ps
module mpm_pin_mux (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       mii_en_i,
  input  wire logic       i2c_en_i,
  // GPIO control from software registers
  input  wire logic [6:0] gpio_g_dir_i,
  input  wire logic [6:0] gpio_g_dat_i,
  input  wire logic [6:0] gpio_h_dir_i,
  input  wire logic [6:0] gpio_h_dat_i,
  input  wire logic [7:0] gpio_j_dir_i,
  input  wire logic [7:0] gpio_j_dat_i,
  output logic      [6:0] gpio_g_in_o,
  output logic      [6:0] gpio_h_in_o,
  output logic      [7:0] gpio_j_in_o,
  // Wakeup configuration and flags
  input  wire logic [6:0] wake_g_en_i,
  input  wire logic [6:0] wake_h_en_i,
  input  wire logic [7:0] wake_j_en_i,
  input  wire logic [6:0] wake_g_pol_i,
  input  wire logic [6:0] wake_h_pol_i,
  input  wire logic [7:0] wake_j_pol_i,
  input  wire logic [6:0] wake_g_clr_i,
  input  wire logic [6:0] wake_h_clr_i,
  input  wire logic [7:0] wake_j_clr_i,
  output logic      [6:0] wake_g_flag_o,
  output logic      [6:0] wake_h_flag_o,
  output logic      [7:0] wake_j_flag_o,
  output logic            wake_req_o,
  // MAC side
  output logic      [3:0] mac_rxd_o,
  output logic            mac_rxdv_o,
  output logic            mac_rxer_o,
  output logic            mac_rxclk_o,
  output logic            mac_txclk_o,
  input  wire logic [3:0] mac_txd_i,
  input  wire logic       mac_txen_i,
  input  wire logic       mac_txer_i,
  output logic            mac_col_o,
  output logic            mac_crs_o,
  input  wire logic       mac_mdio_out_i,
  input  wire logic       mac_mdio_oe_i,
  output logic            mac_mdio_in_o,
  // I2C side (open drain: drive low when oe high)
  input  wire logic       i2c_scl_oe_i,
  input  wire logic       i2c_sda_oe_i,
  output logic            i2c_scl_in_o,
  output logic            i2c_sda_in_o,
  // Pads
  input  wire logic [6:0] pad_g_i,
  output logic      [6:0] pad_g_o,
  output logic      [6:0] pad_g_oe_o,
  input  wire logic [6:0] pad_h_i,
  output logic      [6:0] pad_h_o,
  output logic      [6:0] pad_h_oe_o,
  input  wire logic [7:0] pad_j_i,
  output logic      [7:0] pad_j_o,
  output logic      [7:0] pad_j_oe_o
);
  // ==========================================================================
  // Local constants
  // ==========================================================================
  localparam int PORT_W_L = mpm_pkg::PORT_W;
  // Edges are trusted once both sync stages and the history stage hold pad levels
  localparam logic [1:0] SYNC_FILL = 2'h3;
  // Port H drive in MII mode: every pin except the transmit clock input
  localparam logic [6:0] MII_H_OE = ~(7'h01 << mpm_pkg::H_TXCLK);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    // Two sync stages per port
    logic [6:0] g_s1, g_s2, h_s1, h_s2;
    logic [7:0] j_s1, j_s2;
    // Last synchronised level, for edge detection
    logic [6:0] g_prev, h_prev;
    logic [7:0] j_prev;
    // Sticky wakeup flags
    logic [6:0] g_flag, h_flag;
    logic [7:0] j_flag;
    // Registered pad drive and enables
    logic [6:0] g_o, g_oe, h_o, h_oe;
    logic [7:0] j_o, j_oe;
    // Input pipeline refill count after reset
    logic [1:0] fill;
  } mpm_state_t;

  mpm_state_t st;
  mpm_state_t next_st;

  // Active-edge detect per polarity: pol=1 rising, pol=0 falling
  function automatic logic [7:0] mpm_edge(input logic [7:0] cur, input logic [7:0] prv,
                                          input logic [7:0] pol);
    mpm_edge = (pol & cur & ~prv) | (~pol & ~cur & prv);
  endfunction : mpm_edge

  // ==========================================================================
  // Wakeup edge candidates
  // ==========================================================================
  // Right after reset the history stage holds zeros rather than a pad level,
  // so a pin that idles high would look like a fresh rising edge; the
  // detectors stay off until the input pipeline has been refilled.
  logic       edge_ok;
  logic [7:0] g_edge;
  logic [7:0] h_edge;
  logic [7:0] j_edge;

  assign edge_ok = (st.fill == SYNC_FILL);
  assign g_edge = mpm_edge({1'b0, st.g_s2}, {1'b0, st.g_prev}, {1'b0, wake_g_pol_i})
                  & {8{edge_ok}};                                                    // [R6]
  assign h_edge = mpm_edge({1'b0, st.h_s2}, {1'b0, st.h_prev}, {1'b0, wake_h_pol_i})
                  & {8{edge_ok}};                                                    // [R6]
  assign j_edge = mpm_edge(st.j_s2, st.j_prev, wake_j_pol_i) & {8{edge_ok}};         // [R6]

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st = st;
    // Two-stage synchronisers on all pad inputs
    next_st.g_s1 = pad_g_i;
    next_st.g_s2 = st.g_s1;
    next_st.h_s1 = pad_h_i;
    next_st.h_s2 = st.h_s1;
    next_st.j_s1 = pad_j_i;
    next_st.j_s2 = st.j_s1;
    next_st.g_prev = st.g_s2;
    next_st.h_prev = st.h_s2;
    next_st.j_prev = st.j_s2;
    // Count the refill of the input pipeline after reset
    if (st.fill != SYNC_FILL) begin
      next_st.fill = st.fill + 2'h1;
    end
    // Sticky wakeup flags, set wins over clear
    next_st.g_flag = (st.g_flag & ~wake_g_clr_i) |                                   // [R6]
                     (wake_g_en_i & g_edge[PORT_W_L-1:0]);
    next_st.h_flag = (st.h_flag & ~wake_h_clr_i) |                                   // [R6]
                     (wake_h_en_i & h_edge[PORT_W_L-1:0]);
    next_st.j_flag = (st.j_flag & ~wake_j_clr_i) |                                   // [R6]
                     (wake_j_en_i & j_edge);
    // GPIO defaults for every pin; port J bits 0, 5 and 4 never leave GPIO here
    next_st.g_o  = gpio_g_dat_i;                                                     // [R1]
    next_st.g_oe = gpio_g_dir_i;                                                     // [R1]
    next_st.h_o  = gpio_h_dat_i;                                                     // [R1]
    next_st.h_oe = gpio_h_dir_i;                                                     // [R1]
    next_st.j_o  = gpio_j_dat_i;                                                     // [R1]
    next_st.j_oe = gpio_j_dir_i;                                                     // [R1]
    if (mii_en_i) begin
      // Receive pins become inputs to the MAC
      next_st.g_oe = 7'h00;                                                          // [R2] [R8]
      // Transmit pins: data, enable, error driven; clock pin is an input
      next_st.h_o  = {mac_txer_i, mac_txen_i, 1'b0, mac_txd_i};                     // [R3] [R8]
      next_st.h_oe = MII_H_OE;                                                       // [R3] [R8]
      // Management data: the MAC owns both value and enable
      next_st.j_o[mpm_pkg::J_MDIO]  = mac_mdio_out_i;                                // [R4] [R8]
      next_st.j_oe[mpm_pkg::J_MDIO] = mac_mdio_oe_i;                                 // [R4] [R8]
      // Collision and carrier sense are inputs from the PHY
      next_st.j_oe[mpm_pkg::J_COL]  = 1'b0;                                          // [R4]
      next_st.j_oe[mpm_pkg::J_CRS]  = 1'b0;                                          // [R4]
    end
    if (i2c_en_i) begin
      // Open drain: only ever pull low
      // A released line rises through the external pull-up
      next_st.j_o[mpm_pkg::J_SCL]  = 1'b0;                                           // [R5] [R8]
      next_st.j_oe[mpm_pkg::J_SCL] = i2c_scl_oe_i;                                   // [R5] [R8]
      next_st.j_o[mpm_pkg::J_SDA]  = 1'b0;                                           // [R5] [R8]
      next_st.j_oe[mpm_pkg::J_SDA] = i2c_sda_oe_i;                                   // [R5] [R8]
    end
    if (srst_i) begin
      next_st = '0;                                                                  // [R7]
      next_st.g_oe = mpm_pkg::RST_DIR7;                                              // [R7]
      next_st.h_oe = mpm_pkg::RST_DIR7;                                              // [R7]
      next_st.j_oe = mpm_pkg::RST_DIR8;                                              // [R7]
      next_st.g_o  = mpm_pkg::RST_DAT7;                                              // [R7]
      next_st.h_o  = mpm_pkg::RST_DAT7;                                              // [R7]
      next_st.j_o  = mpm_pkg::RST_DAT8;                                              // [R7]
    end
  end

  // Register the whole state
  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Pad drive
  assign pad_g_o    = st.g_o;
  assign pad_g_oe_o = st.g_oe;
  assign pad_h_o    = st.h_o;
  assign pad_h_oe_o = st.h_oe;
  assign pad_j_o    = st.j_o;
  assign pad_j_oe_o = st.j_oe;
  // Synchronised pin levels back to software and peripherals
  assign gpio_g_in_o = st.g_s2;
  assign gpio_h_in_o = st.h_s2;
  assign gpio_j_in_o = st.j_s2;
  assign mac_rxd_o   = st.g_s2[3:0];                                                 // [R2]
  assign mac_rxdv_o  = st.g_s2[mpm_pkg::G_RXDV];                                     // [R2]
  assign mac_rxer_o  = st.g_s2[mpm_pkg::G_RXER];                                     // [R2]
  assign mac_rxclk_o = st.g_s2[mpm_pkg::G_RXCLK];                                    // [R2]
  assign mac_txclk_o = st.h_s2[mpm_pkg::H_TXCLK];                                    // [R3]
  assign mac_col_o   = st.j_s2[mpm_pkg::J_COL];                                      // [R4]
  assign mac_crs_o   = st.j_s2[mpm_pkg::J_CRS];                                      // [R4]
  assign mac_mdio_in_o = st.j_s2[mpm_pkg::J_MDIO];                                   // [R4]
  assign i2c_scl_in_o  = st.j_s2[mpm_pkg::J_SCL];                                    // [R5]
  assign i2c_sda_in_o  = st.j_s2[mpm_pkg::J_SDA];                                    // [R5]
  // Wakeup flags and combined request
  assign wake_g_flag_o = st.g_flag;
  assign wake_h_flag_o = st.h_flag;
  assign wake_j_flag_o = st.j_flag;
  assign wake_req_o    = |{st.g_flag, st.h_flag, st.j_flag};                         // [R6]
endmodule : mpm_pin_mux

// *** sim/mpm_pin_mux_checker.sv ***
// Port-level checks on the pin multiplexer.
`timescale 1ns/1ps
module mpm_pin_mux_checker (
  input wire logic       core_clk_i, srst_i, mii_en_i, i2c_en_i, mac_txen_i, mac_txer_i,
  input wire logic       mac_mdio_out_i, mac_mdio_oe_i, i2c_scl_oe_i, i2c_sda_oe_i,
  input wire logic [3:0] mac_txd_i, mac_rxd_o,
  input wire logic [6:0] gpio_g_dir_i, gpio_g_dat_i, gpio_g_in_o, pad_g_i, pad_g_o, pad_g_oe_o,
  input wire logic [6:0] pad_h_o, pad_h_oe_o, wake_g_flag_o, wake_g_en_i, wake_g_pol_i,
  input wire logic [7:0] pad_j_o, pad_j_oe_o
);
  // ==========================================================================
  // Pad ownership and input paths
  // ==========================================================================
  default clocking cb @(posedge core_clk_i); endclocking
  AST_RST_HIZ:
    assert property (srst_i |=> (pad_g_oe_o | pad_h_oe_o) == 7'h00 && pad_j_oe_o == 8'h00)
    else $error("pad driven after reset");
  AST_GPIO_G:
    assert property (disable iff (srst_i) !mii_en_i |=> pad_g_oe_o == $past(gpio_g_dir_i)
      && (pad_g_o & pad_g_oe_o) == ($past(gpio_g_dat_i) & $past(gpio_g_dir_i)))
    else $error("port g gpio drive wrong");
  AST_MII_H:
    assert property (disable iff (srst_i) mii_en_i |=> pad_g_oe_o == 7'h00
      && pad_h_oe_o == 7'h6F && pad_h_o[3:0] == $past(mac_txd_i)
      && pad_h_o[6:5] == {$past(mac_txer_i), $past(mac_txen_i)})
    else $error("mii transmit mux wrong");
  AST_MII_J:
    assert property (disable iff (srst_i) mii_en_i |=> pad_j_oe_o[3:1] == {2'b00,
      $past(mac_mdio_oe_i)} && (!pad_j_oe_o[1] || pad_j_o[1] == $past(mac_mdio_out_i)))
    else $error("mii management mux wrong");
  AST_I2C:
    assert property (disable iff (srst_i) i2c_en_i |=> pad_j_o[7:6] == 2'b00
      && pad_j_oe_o[7:6] == {$past(i2c_scl_oe_i), $past(i2c_sda_oe_i)})
    else $error("i2c mux wrong");
  AST_RX_SYNC:
    assert property (disable iff (srst_i) mii_en_i && $past(mii_en_i) && $past(mii_en_i, 2)
      && !$past(srst_i) && !$past(srst_i, 2) |-> {3'b000, mac_rxd_o} == ($past(pad_g_i, 2) & 7'h0F))
    else $error("receive nibble wrong");
  AST_GPIO_IN:
    assert property (disable iff (srst_i) !$past(srst_i) && !$past(srst_i, 2)
      |-> gpio_g_in_o == $past(pad_g_i, 2))
    else $error("port g input wrong");
  AST_WAKE_SET:
    assert property (disable iff (srst_i) !$past(srst_i)
      && $rose(pad_g_i[2]) && wake_g_en_i[2] && wake_g_pol_i[2]
      |-> ##3 wake_g_flag_o[2])
    else $error("wakeup flag not set");
endmodule : mpm_pin_mux_checker
bind mpm_pin_mux mpm_pin_mux_checker i_chk (.*);

// *** sim/mpm_phy_model.sv ***
// Far side: PHY and I2C devices resolving every pad wire.
`timescale 1ns/1ps
module mpm_phy_model (
  input  wire logic [6:0] pad_g_o, pad_g_oe_o, pad_h_o, pad_h_oe_o, drv_g, drv_h,
  input  wire logic [7:0] pad_j_o, pad_j_oe_o, drv_j,
  output logic      [6:0] pad_g_i, pad_h_i,
  output logic      [7:0] pad_j_i
);
  // PHY drives receive, clock, collision and carrier pins the chip leaves free
  assign pad_g_i = (pad_g_oe_o & pad_g_o) | (~pad_g_oe_o & drv_g);
  assign pad_h_i = (pad_h_oe_o & pad_h_o) | (~pad_h_oe_o & drv_h);
  assign pad_j_i[5:0] = (pad_j_oe_o[5:0] & pad_j_o[5:0]) | (~pad_j_oe_o[5:0] & drv_j[5:0]);
  // Clock and data lines are wired-and with a pull-up
  assign pad_j_i[7:6] = ~(pad_j_oe_o[7:6] & ~pad_j_o[7:6]) & drv_j[7:6];
endmodule : mpm_phy_model

// *** sim/mpm_pin_mux_bench.sv ***
// Self-checking bench for the pin multiplexer.
`timescale 1ns/1ps
module mpm_pin_mux_bench;
  logic core_clk_i, srst_i, mii_en_i, i2c_en_i, mac_txen_i, mac_txer_i, mac_mdio_out_i;
  logic mac_mdio_oe_i, i2c_scl_oe_i, i2c_sda_oe_i, wake_req_o, mac_rxdv_o, mac_rxer_o;
  logic mac_rxclk_o, mac_txclk_o, mac_col_o, mac_crs_o, mac_mdio_in_o, i2c_scl_in_o, i2c_sda_in_o;
  logic [3:0] mac_rxd_o, mac_txd_i;
  logic [6:0] gpio_g_dir_i, gpio_g_dat_i, gpio_h_dir_i, gpio_h_dat_i, gpio_g_in_o, gpio_h_in_o;
  logic [6:0] wake_g_en_i, wake_h_en_i, wake_g_pol_i, wake_h_pol_i, wake_g_clr_i, wake_h_clr_i;
  logic [6:0] wake_g_flag_o, wake_h_flag_o, pad_g_i, pad_g_o, pad_g_oe_o, pad_h_i, pad_h_o;
  logic [6:0] pad_h_oe_o, drv_g, drv_h;
  logic [7:0] gpio_j_dir_i, gpio_j_dat_i, gpio_j_in_o, wake_j_en_i, wake_j_pol_i, wake_j_clr_i;
  logic [7:0] wake_j_flag_o, pad_j_i, pad_j_o, pad_j_oe_o, drv_j;
  int errors, checks;
  mpm_pin_mux i_mpm_pin_mux (.*);
  mpm_phy_model i_mpm_phy_model (.*);
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic close_out;
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
  // Reset, wakeup, gpio, mii and i2c sequences
  initial begin
    srst_i = 1'b1;
    {mii_en_i, i2c_en_i, mac_txen_i, mac_txer_i, mac_mdio_out_i, mac_mdio_oe_i} = '0;
    {i2c_scl_oe_i, i2c_sda_oe_i, mac_txd_i, drv_g, drv_h, gpio_g_dat_i, gpio_h_dat_i} = '0;
    {gpio_h_dir_i, gpio_j_dat_i, wake_g_en_i, wake_h_en_i, wake_j_en_i, wake_g_pol_i} = '0;
    {wake_h_pol_i, wake_j_pol_i, wake_g_clr_i, wake_h_clr_i, wake_j_clr_i} = '0;
    gpio_g_dir_i = 7'h7F;
    gpio_j_dir_i = 8'hFF;
    drv_j = 8'hC0;
    step(8);
    chk(pad_j_oe_o | {1'b0, pad_g_oe_o}, 8'h00);
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    gpio_g_dir_i <= 7'h00;
    gpio_j_dir_i <= 8'h00;
    wake_g_en_i <= 7'h7F;
    wake_g_pol_i <= 7'h7F;
    wake_j_en_i <= 8'h80;
    step(1);
    chk(pad_j_oe_o | {1'b0, pad_g_oe_o}, 8'h00);
    @(posedge core_clk_i);
    drv_g <= 7'h04;
    step(3);
    chk({1'b0, wake_g_flag_o}, 8'h04);
    chk({1'b0, gpio_g_in_o}, 8'h04);
    step(1);
    chk({7'h00, wake_req_o}, 8'h01);
    wake_g_clr_i <= 7'h7F;
    step(1);
    chk({1'b0, wake_g_flag_o}, 8'h00);
    wake_g_clr_i <= 7'h00;
    gpio_g_dir_i <= 7'h7F;
    gpio_g_dat_i <= 7'h55;
    gpio_h_dir_i <= 7'h0F;
    gpio_h_dat_i <= 7'h3A;
    gpio_j_dir_i <= 8'hFF;
    gpio_j_dat_i <= 8'hA5;
    step(1);
    chk({1'b0, pad_g_o}, 8'h55);
    chk({1'b0, pad_h_oe_o}, 8'h0F);
    chk({1'b0, pad_h_o & pad_h_oe_o}, 8'h0A);
    chk(pad_j_o, 8'hA5);
    @(posedge core_clk_i);
    mii_en_i <= 1'b1;
    mac_txd_i <= 4'hA;
    mac_txen_i <= 1'b1;
    mac_txer_i <= 1'b1;
    wake_h_en_i <= 7'h20;
    mac_mdio_oe_i <= 1'b1;
    mac_mdio_out_i <= 1'b1;
    drv_g <= 7'h5B;
    drv_h <= 7'h10;
    drv_j <= 8'hCC;
    step(3);
    chk({1'b0, pad_g_oe_o}, 8'h00);
    chk({1'b0, pad_h_oe_o}, 8'h6F);
    chk({1'b0, pad_h_o & 7'h6F}, 8'h6A);
    chk({1'b0, mac_rxer_o, mac_rxdv_o, mac_rxclk_o, mac_rxd_o}, 8'h5B);
    chk({4'h0, mac_txclk_o, mac_col_o, mac_crs_o, mac_mdio_in_o}, 8'h0F);
    chk(pad_j_oe_o & 8'h0E, 8'h02);
    mac_mdio_oe_i <= 1'b0;
    drv_j <= 8'hC8;
    step(3);
    chk({5'h00, mac_col_o, mac_crs_o, mac_mdio_in_o}, 8'h04);
    mii_en_i <= 1'b0;
    i2c_en_i <= 1'b1;
    i2c_scl_oe_i <= 1'b1;
    step(3);
    chk(pad_j_oe_o & 8'hC0, 8'h80);
    chk({6'h00, i2c_scl_in_o, i2c_sda_in_o}, 8'h01);
    chk(gpio_j_in_o, 8'h65);
    chk({1'b0, gpio_h_in_o}, 8'h1A);
    step(1);
    chk(wake_j_flag_o & 8'h80, 8'h80);
    chk({1'b0, wake_h_flag_o}, 8'h20);
    i2c_en_i <= 1'b0;
    step(1);
    chk(pad_j_o, 8'hA5);
    // Mid-run reset: pins float, flags clear, no false edge after release
    srst_i <= 1'b1;
    step(1);
    chk(pad_j_oe_o | {1'b0, pad_g_oe_o | pad_h_oe_o}, 8'h00);
    chk({7'h00, wake_req_o}, 8'h00);
    srst_i <= 1'b0;
    gpio_g_dir_i <= 7'h00;
    gpio_h_dir_i <= 7'h00;
    gpio_j_dir_i <= 8'h00;
    step(1);
    chk(pad_j_oe_o | {1'b0, pad_g_oe_o | pad_h_oe_o}, 8'h00);
    step(4);
    chk({1'b0, wake_g_flag_o}, 8'h00);
    chk({1'b0, gpio_g_in_o}, 8'h5B);
    close_out();
  end
endmodule : mpm_pin_mux_bench
